// ==== fcm_clock_mode.sv ====
// Clock source mode controller: loop, reference dividers and clock gating.
module fcm_clock_mode
   import fcm_pkg::*;
#(
   parameter int unsigned IREF_BASE = IREF_BASE_CYC
) (
   input  wire logic         clk,               // System clock, 250 MHz.
   input  wire logic         srst,              // Reset, trim kept.
   input  wire logic         por,               // Power-on reset, all.
   input  wire fcm_bus_req_t bus_req,           // Register access.
   output      logic [7:0]   rdata,             // Read data, next cycle.
   input  wire logic         ext_ref_tick,      // External reference edge.
   input  wire logic         ext_ref_ready,     // External source usable.
   input  wire logic         debug_mode_active, // Debug session running.
   input  wire logic         stop_mode,         // Processor in stop.
   output      fcm_clk_out_t clk_out            // Clock enables and flag.
);

   // ****************************************************************
   // State and combinational helpers
   // ****************************************************************
   fcm_state_t        st_ff;
   fcm_state_t        nxt_st;
   logic [IREF_W-1:0] iref_period;
   logic              iref_run;
   logic              ext_tick;
   logic              ref_tick;
   logic [6:0]        reference_divider_mask;
   logic              loop_off;
   logic              loop_run;
   logic [MEAS_W-1:0] fll_div;
   logic              want_avail;
   logic              want_tick;
   logic              src_tick;
   logic [2:0]        bus_mask;
   logic [2:0]        ffe_limit;
   logic              ffe_bypass;

   assign rdata   = st_ff.rdata;
   assign clk_out = st_ff.outs;

   always_comb begin
      nxt_st             = st_ff;
      nxt_st.rdata       = 8'h00;
      nxt_st.iref_tick   = 1'b0;
      nxt_st.ff_tick     = 1'b0;
      nxt_st.fll_tick    = 1'b0;

      // ****************************************************************
      // Register writes and reads
      // ****************************************************************
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ADDR_CTRL1: begin
               nxt_st.cs       = fcm_src_t'(bus_req.wdata[C1_CS_LSB +: 2]);
               nxt_st.reference_divider     = bus_req.wdata[C1_REFERENCE_DIVIDER_LSB +: 3];
               nxt_st.internal_ref_select    = bus_req.wdata[C1_INTERNAL_REF_SELECT];
               nxt_st.internal_ref_out_enable  = bus_req.wdata[C1_INTERNAL_REF_OUT_ENABLE];
               nxt_st.internal_ref_stop_enable = bus_req.wdata[C1_IRSTEN];
            end
            ADDR_CTRL2: begin
               nxt_st.bus_divider     = bus_req.wdata[C2_BUS_DIVIDER_LSB +: 2];
               nxt_st.lp       = bus_req.wdata[C2_LP];
               nxt_st.external_ref_out_enable  = bus_req.wdata[C2_EXTERNAL_REF_OUT_ENABLE];
               nxt_st.external_ref_stop_enable = bus_req.wdata[C2_ERSTEN];
            end
            ADDR_TRIM: nxt_st.trim  = bus_req.wdata;
            ADDR_STAT: nxt_st.fine_period_bit = bus_req.wdata[ST_FINE_PERIOD_BIT];
            default: ;
         endcase
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_CTRL1: nxt_st.rdata = {st_ff.cs, st_ff.reference_divider, st_ff.internal_ref_select,
                                        st_ff.internal_ref_out_enable, st_ff.internal_ref_stop_enable};
            ADDR_CTRL2: nxt_st.rdata = {st_ff.bus_divider, 2'h0, st_ff.lp, 1'b0,
                                        st_ff.external_ref_out_enable, st_ff.external_ref_stop_enable};
            ADDR_TRIM:  nxt_st.rdata = st_ff.trim;
            // Mode status reflects the source in use, not the one written.
            ADDR_STAT:  nxt_st.rdata = {3'h0, st_ff.locked, st_ff.cur_src,
                                        ext_ref_ready, st_ff.fine_period_bit};
            default:    nxt_st.rdata = 8'h00;
         endcase
      end

      // ****************************************************************
      // Internal reference oscillator
      // ****************************************************************
      // Trim and fine bit form one 9-bit period extension.
      iref_period = IREF_W'(IREF_BASE)
                  + IREF_W'({st_ff.trim, st_ff.fine_period_bit});
      // In stop the oscillator sleeps unless both enables are set; outside stop it sleeps while nothing selects, enables or uses it.
      iref_run = stop_mode ? (st_ff.internal_ref_out_enable & st_ff.internal_ref_stop_enable)
               : (st_ff.internal_ref_select | st_ff.internal_ref_out_enable
                  | (st_ff.cs == FCM_SRC_INT)
                  | (st_ff.cur_src == FCM_SRC_INT));
      if (!iref_run) begin
         nxt_st.iref_cnt = '0;
      end else if (st_ff.iref_cnt >= iref_period - IREF_W'(1)) begin
         nxt_st.iref_cnt  = '0;
         nxt_st.iref_tick = 1'b1;
      end else begin
         nxt_st.iref_cnt = st_ff.iref_cnt + IREF_W'(1);
      end

      // ****************************************************************
      // Reference divider and fixed-frequency clock
      // ****************************************************************
      ext_tick  = ext_ref_tick & ext_ref_ready;
      // With internal select the external edges never reach the loop.
      ref_tick  = st_ff.internal_ref_select ? st_ff.iref_tick : ext_tick;
      reference_divider_mask = 7'h7f >> (3'h7 - st_ff.reference_divider);
      if (ref_tick && !stop_mode) begin
         if (st_ff.reference_divider_cnt >= reference_divider_mask) begin
            nxt_st.reference_divider_cnt = '0;
            nxt_st.ff_tick  = 1'b1;
         end else begin
            nxt_st.reference_divider_cnt = st_ff.reference_divider_cnt + 7'h01;
         end
      end

      // ****************************************************************
      // Frequency-locked loop
      // ****************************************************************
      // Debug keeps the loop alive outside stop so the link clock stays usable.
      loop_off = (st_ff.cs != FCM_SRC_LOOP) & st_ff.lp
               & ~debug_mode_active;
      loop_run = ~loop_off & ~stop_mode;
      nxt_st.internal_ref_select_seen = st_ff.internal_ref_select;
      if (!loop_run || (st_ff.internal_ref_select != st_ff.internal_ref_select_seen)) begin
         nxt_st.locked   = 1'b0;
         nxt_st.lock_cnt = 2'h0;
         nxt_st.meas_cnt = '0;
      end else if (st_ff.ff_tick) begin
         nxt_st.ref_period = st_ff.meas_cnt + MEAS_W'(1);
         nxt_st.meas_cnt   = '0;
         if (!st_ff.locked) begin
            if (st_ff.lock_cnt == RELOCK_TICKS - 2'h1) begin
               nxt_st.locked = 1'b1;
            end else begin
               nxt_st.lock_cnt = st_ff.lock_cnt + 2'h1;
            end
         end
      end else if (st_ff.meas_cnt != '1) begin
         nxt_st.meas_cnt = st_ff.meas_cnt + MEAS_W'(1);
      end
      // Output period is the measured reference period over 512.
      fll_div = st_ff.ref_period >> FLL_SHIFT;
      if (fll_div == '0) begin
         fll_div = MEAS_W'(1);
      end
      if (loop_run && st_ff.locked) begin
         if (st_ff.fll_cnt >= fll_div - MEAS_W'(1)) begin
            nxt_st.fll_cnt  = '0;
            nxt_st.fll_tick = 1'b1;
         end else begin
            nxt_st.fll_cnt = st_ff.fll_cnt + MEAS_W'(1);
         end
      end else begin
         nxt_st.fll_cnt = '0;
      end

      // ****************************************************************
      // Source switching
      // ****************************************************************
      unique case (st_ff.cs)
         FCM_SRC_LOOP: begin
            want_avail = st_ff.locked;
            want_tick  = st_ff.fll_tick;
         end
         FCM_SRC_INT: begin
            want_avail = 1'b1;
            want_tick  = st_ff.iref_tick;
         end
         FCM_SRC_EXT: begin
            want_avail = ext_ref_ready;
            want_tick  = ext_tick;
         end
         default: begin
            want_avail = 1'b0;
            want_tick  = 1'b0;
         end
      endcase
      if (st_ff.cs != st_ff.pend_src) begin
         nxt_st.pend_src = st_ff.cs;
         nxt_st.sw_cnt   = 2'h0;
      end else if (st_ff.cs == st_ff.cur_src || !want_avail) begin
         // A source that is not running leaves the old one selected.
         nxt_st.sw_cnt = 2'h0;
      end else if (want_tick) begin
         if (st_ff.sw_cnt == SWITCH_TICKS - 2'h1) begin
            nxt_st.cur_src = st_ff.cs;
            nxt_st.sw_cnt  = 2'h0;
         end else begin
            nxt_st.sw_cnt = st_ff.sw_cnt + 2'h1;
         end
      end

      // ****************************************************************
      // Bus divider and clock outputs
      // ****************************************************************
      unique case (st_ff.cur_src)
         FCM_SRC_LOOP: src_tick = st_ff.fll_tick;
         FCM_SRC_INT:  src_tick = st_ff.iref_tick;
         FCM_SRC_EXT:  src_tick = ext_tick;
         default:      src_tick = 1'b0;
      endcase
      // The mask follows the live divider field, so a change acts at once.
      bus_mask = 3'h7 >> (2'h3 - st_ff.bus_divider);
      if (src_tick && !stop_mode) begin
         nxt_st.bus_cnt = st_ff.bus_cnt + 3'h1;
      end
      nxt_st.outs.main_clk = src_tick & ~stop_mode
                           & ((st_ff.bus_cnt & bus_mask) == bus_mask);
      nxt_st.outs.link_clk = st_ff.fll_tick & loop_run;
      nxt_st.outs.iref_clk = st_ff.iref_tick & st_ff.internal_ref_out_enable
                           & (~stop_mode | st_ff.internal_ref_stop_enable);
      nxt_st.outs.eref_clk = ext_tick & st_ff.external_ref_out_enable
                           & (~stop_mode | st_ff.external_ref_stop_enable);
      nxt_st.outs.ff_clk   = st_ff.ff_tick & ~stop_mode;
      ffe_limit  = FFE_REFERENCE_DIVIDER_BASE + {1'b0, st_ff.bus_divider};
      ffe_bypass = (st_ff.reference_divider >= ffe_limit);
      nxt_st.outs.ffe = (st_ff.cur_src == FCM_SRC_LOOP)
                      | ffe_bypass;

      // ****************************************************************
      // Reset
      // ****************************************************************
      if (srst || por) begin
         nxt_st          = '0;
         nxt_st.cs       = fcm_src_t'(CS_RST);
         nxt_st.pend_src = fcm_src_t'(CS_RST);
         nxt_st.cur_src  = fcm_src_t'(CS_RST);
         nxt_st.reference_divider     = REFERENCE_DIVIDER_RST;
         nxt_st.internal_ref_select    = INTERNAL_REF_SELECT_RST;
         nxt_st.internal_ref_select_seen = INTERNAL_REF_SELECT_RST;
         nxt_st.bus_divider     = BUS_DIVIDER_RST;
         nxt_st.outs.ffe = 1'b1;
         // Trim only returns to its default on power-up.
         nxt_st.trim     = por ? TRIM_POR : st_ff.trim;
         nxt_st.fine_period_bit    = por ? FINE_PERIOD_BIT_POR : st_ff.fine_period_bit;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst || por);

   link_withheld_a: assert property (
      loop_off [*2] |=> !st_ff.outs.link_clk)
      else $error("link clock ran while loop was off");
   stop_static_a: assert property (
      stop_mode [*2] |=> !st_ff.outs.main_clk && !st_ff.outs.ff_clk
                         && !st_ff.outs.link_clk)
      else $error("clock output toggled in stop");
   iref_stop_a: assert property (
      stop_mode && !(st_ff.internal_ref_out_enable && st_ff.internal_ref_stop_enable)
      |=> !st_ff.outs.iref_clk)
      else $error("internal reference ran in stop");
   eref_stop_a: assert property (
      stop_mode && !(st_ff.external_ref_out_enable && st_ff.external_ref_stop_enable)
      |=> !st_ff.outs.eref_clk)
      else $error("external reference ran in stop");
   ffe_engaged_a: assert property (
      st_ff.cur_src == FCM_SRC_LOOP |=> st_ff.outs.ffe)
      else $error("fixed-frequency flag low in engaged mode");
   ffe_bypass_a: assert property (
      st_ff.cur_src != FCM_SRC_LOOP && st_ff.bus_divider == 2'h3
      && st_ff.reference_divider < 3'h5 |=> !st_ff.outs.ffe)
      else $error("fixed-frequency flag high below threshold");
   rsvd_hold_a: assert property (
      st_ff.cs == FCM_SRC_RSVD |=> st_ff.cur_src == $past(st_ff.cur_src))
      else $error("reserved select changed the source");
   ext_unavail_a: assert property (
      st_ff.cs == FCM_SRC_EXT && !ext_ref_ready
      && st_ff.cur_src != FCM_SRC_EXT |=> st_ff.cur_src != FCM_SRC_EXT)
      else $error("switched to unavailable external source");
   relock_a: assert property (
      st_ff.internal_ref_select != st_ff.internal_ref_select_seen |=> !st_ff.locked ##1 !st_ff.locked)
      else $error("loop stayed locked after reference change");
   bus_div1_a: assert property (
      src_tick && !stop_mode && st_ff.bus_divider == 2'h0 |=> st_ff.outs.main_clk)
      else $error("divide-by-one missed a source tick");
   iref_out_a: assert property (
      st_ff.iref_tick && st_ff.internal_ref_out_enable && !stop_mode
      |=> st_ff.outs.iref_clk)
      else $error("internal reference output missing");
   trim_keep_a: assert property (
      @(posedge clk) disable iff (por)
      srst |=> st_ff.trim == $past(st_ff.trim))
      else $error("trim lost over reset");

   // ****************************************************************
   // Reset values, switching and the enabled side of the gating
   // ****************************************************************
   // These cover the reference, fixed-frequency and flag outputs that must run, not only those held still.
   reset_bus_divider_a: assert property (
      @(posedge clk) disable iff (por)
      srst |=> st_ff.bus_divider == BUS_DIVIDER_RST)
      else $error("bus divider not at its reset code");
   reset_mode_a: assert property (
      @(posedge clk) disable iff (por)
      srst |=> st_ff.cs == FCM_SRC_LOOP && st_ff.internal_ref_select == INTERNAL_REF_SELECT_RST)
      else $error("reset did not select loop engaged internal");
   src_follow_a: assert property (
      !$past(srst) && $changed(st_ff.cur_src)
      |-> st_ff.cur_src == $past(st_ff.cs)
      && $past(st_ff.sw_cnt) == SWITCH_TICKS - 2'h1)
      else $error("source switched without counted ticks");
   eref_out_a: assert property (
      ext_ref_tick && ext_ref_ready && st_ff.external_ref_out_enable && !stop_mode
      |=> st_ff.outs.eref_clk)
      else $error("external reference output missing");
   ff_out_a: assert property (
      st_ff.ff_tick && !stop_mode |=> st_ff.outs.ff_clk)
      else $error("fixed-frequency clock pulse missing");
   ext_feeds_a: assert property (
      !st_ff.internal_ref_select && ext_ref_tick && ext_ref_ready && !stop_mode
      |=> st_ff.ff_tick || st_ff.reference_divider_cnt != $past(st_ff.reference_divider_cnt))
      else $error("external edge did not reach the divider");
   bus_div8_a: assert property (
      src_tick && !stop_mode && st_ff.bus_divider == 2'h3
      && st_ff.bus_cnt != 3'h7 |=> !st_ff.outs.main_clk)
      else $error("divide-by-eight passed an early tick");
   ffe_div1_a: assert property (
      st_ff.bus_divider == 2'h0 && st_ff.reference_divider >= 3'h2 |=> st_ff.outs.ffe)
      else $error("fixed-frequency flag low above threshold");
   stat_mode_a: assert property (
      bus_req.rd && bus_req.addr == ADDR_STAT
      |=> rdata[ST_MODE_LSB +: 2] == $past(st_ff.cur_src))
      else $error("mode status differs from source in use");
   iref_stop_run_a: assert property (
      stop_mode && st_ff.internal_ref_out_enable && st_ff.internal_ref_stop_enable && st_ff.iref_tick
      |=> st_ff.outs.iref_clk)
      else $error("internal reference stopped despite enables");
   eref_stop_run_a: assert property (
      stop_mode && st_ff.external_ref_out_enable && st_ff.external_ref_stop_enable
      && ext_ref_tick && ext_ref_ready |=> st_ff.outs.eref_clk)
      else $error("external reference stopped despite enables");
   loop_off_unlock_a: assert property (
      loop_off |=> !st_ff.locked)
      else $error("loop stayed locked while switched off");

endmodule

// ==== fcm_clock_mode_tb_top.sv ====
// Self-checking testbench for the clock source mode controller.
module fcm_clock_mode_tb_top
   import fcm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Harness
   // ****************************************************************
   localparam int IB = 20;
   localparam int EP = 10;
   localparam int MC = 5;
   localparam int LC = 4;
   localparam int IC = 3;
   localparam int EC = 2;
   logic         clk, srst, por, dbg, stp, xrun, xtick, xrdy;
   fcm_bus_req_t req;
   logic [7:0]   rdata;
   fcm_clk_out_t co;
   logic [5:0]   cv;
   int           error_cnt, total_checks;
   assign cv = co;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   fcm_clock_mode #(.IREF_BASE(IB)) dut_u (.clk(clk), .srst(srst),
      .por(por), .bus_req(req), .rdata(rdata), .ext_ref_tick(xtick),
      .ext_ref_ready(xrdy), .debug_mode_active(dbg), .stop_mode(stp),
      .clk_out(co));
   fcm_ext_ref_model #(.PER(EP), .START(30)) xref_u (.clk(clk),
      .run(xrun), .tick(xtick), .ready(xrdy));
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic hang();
      error_cnt++;
      $display("[ERR] wait limit exp 0 got 1");
      print_verdict();
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   // The first gaps may straddle a setting change, so the third is kept.
   task automatic per(input int b, output int n);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (cv[b] !== 1'b1 && n < 3000);
      end
      if (n >= 3000) hang();
   endtask
   task automatic cnt(input int b, input int c, output int n);
      n = 0;
      repeat (c) begin
         @(posedge clk);
         #1 n += (cv[b] === 1'b1);
      end
   endtask
   task automatic wst(input logic [7:0] m, input logic [7:0] v);
      logic [7:0] d;
      int i;
      for (i = 0; i < 3000; i++) begin
         rd(ADDR_STAT, d);
         if ((d & m) === v) break;
      end
      if (i == 3000) hang();
      else chk("stat", v, d & m);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      logic [7:0] d;
      rd(ADDR_CTRL1, d);
      chk("ctrl1", 8'h04, d);
      rd(ADDR_CTRL2, d);
      chk("ctrl2", 8'h40, d);
      rd(ADDR_TRIM, d);
      chk("trim", 8'h80, d);
      rd(ADDR_STAT, d);
      chk("stat", 8'h00, d);
      rd(3'h5, d);
      chk("unmapped", 8'h00, d);
      chk("ffe", 1'b1, co.ffe);
   endtask
   task automatic t_trim();
      int n;
      logic [7:0] d;
      wr(ADDR_TRIM, 8'h00);
      wr(ADDR_STAT, 8'h00);
      wr(ADDR_CTRL1, 8'h06);
      per(IC, n);
      chk("iref per", IB, n);
      wr(ADDR_TRIM, 8'h01);
      wr(ADDR_STAT, 8'h01);
      per(IC, n);
      chk("iref per", IB + 3, n);
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd(ADDR_TRIM, d);
      chk("trim kept", 8'h01, d);
      rd(ADDR_STAT, d);
      chk("fine kept", 1'b1, d[0]);
      wr(ADDR_TRIM, 8'h00);
      wr(ADDR_STAT, 8'h00);
   endtask
   task automatic t_lock();
      int n;
      wr(ADDR_CTRL1, 8'h36);
      repeat (6000) @(posedge clk);
      wst(8'h1c, 8'h10);
      per(LC, n);
      chk("loop per", 2, n);
      per(MC, n);
      chk("main per", 4, n);
      per(1, n);
      chk("ff per", IB << 6, n);
   endtask
   task automatic t_bypass();
      int n;
      wr(ADDR_CTRL1, 8'h46);
      wst(8'h0c, 8'h04);
      for (int b = 0; b < 4; b++) begin
         wr(ADDR_CTRL2, {b[1:0], 6'h00});
         per(MC, n);
         chk("main per", IB << b, n);
      end
      wr(ADDR_CTRL2, 8'h40);
      cnt(LC, 200, n);
      chk("link on", 1'b1, n > 0);
      wr(ADDR_CTRL2, 8'h48);
      repeat (4) @(posedge clk);
      cnt(LC, 200, n);
      chk("link off", 0, n);
      @(posedge clk);
      dbg <= 1'b1;
      cnt(LC, 300, n);
      chk("link dbg", 1'b1, n > 0);
      @(posedge clk);
      dbg <= 1'b0;
      wr(ADDR_CTRL1, 8'hc6);
      repeat (100) @(posedge clk);
      wst(8'h0c, 8'h04);
      wr(ADDR_CTRL2, 8'h40);
   endtask
   task automatic t_ffe();
      for (int b = 0; b < 4; b++) begin
         wr(ADDR_CTRL2, {b[1:0], 6'h00});
         for (int r = 1; r < 3; r++) begin
            wr(ADDR_CTRL1, {2'b01, 3'(b + r), 3'b110});
            repeat (3) @(posedge clk);
            #1 chk("ffe", r == 2, co.ffe);
         end
      end
      wr(ADDR_CTRL1, 8'h46);
      wr(ADDR_CTRL2, 8'h40);
   endtask
   task automatic t_stop();
      int n;
      wr(ADDR_CTRL1, 8'h47);
      stp <= 1'b1;
      cnt(IC, 100, n);
      chk("iref stop", 100 / IB, n);
      cnt(MC, 100, n);
      chk("main stop", 0, n);
      wr(ADDR_CTRL1, 8'h46);
      cnt(IC, 100, n);
      chk("iref gated", 0, n);
      @(posedge clk);
      stp <= 1'b0;
   endtask
   task automatic t_ext();
      int n;
      wr(ADDR_CTRL2, 8'h4b);
      wr(ADDR_CTRL1, 8'h80);
      repeat (100) @(posedge clk);
      wst(8'h0c, 8'h04);
      @(posedge clk);
      xrun <= 1'b1;
      wst(8'h0c, 8'h08);
      per(MC, n);
      chk("main ext", EP * 2, n);
      cnt(LC, 200, n);
      chk("link off", 0, n);
      cnt(EC, 100, n);
      chk("eref", 100 / EP, n);
      @(posedge clk);
      dbg <= 1'b1;
      cnt(LC, 300, n);
      chk("link dbg", 1'b1, n > 0);
      @(posedge clk);
      dbg <= 1'b0;
      stp <= 1'b1;
      cnt(EC, 100, n);
      chk("eref stop", 100 / EP, n);
      cnt(MC, 100, n);
      chk("main stop", 0, n);
      @(posedge clk);
      stp <= 1'b0;
      wr(ADDR_CTRL1, 8'h00);
      wst(8'h0c, 8'h00);
      cnt(LC, 100, n);
      chk("link fee", 1'b1, n > 0);
      chk("ffe", 1'b1, co.ffe);
   endtask
   initial begin
      error_cnt = 0;
      total_checks = 0;
      srst = 1'b1;
      por = 1'b1;
      dbg = 1'b0;
      stp = 1'b0;
      xrun = 1'b0;
      req = '0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      por <= 1'b0;
      t_reset();
      t_trim();
      t_lock();
      t_bypass();
      t_ffe();
      t_stop();
      t_ext();
      print_verdict();
   end
endmodule

// ==== fcm_ext_ref_model.sv ====
// External reference oscillator model driving the controller's reference input.
module fcm_ext_ref_model #(
   parameter int PER   = 10, // Reference period in clk cycles.
   parameter int START = 30  // Start-up cycles before the source is usable.
) (
   input  wire logic clk,   // System clock.
   input  wire logic run,   // Oscillator powered.
   output      logic tick,  // One pulse per reference period.
   output      logic ready  // Source started and stable.
);
   timeunit 1ns;
   timeprecision 1ps;
   // The bench holds run low from the start, so the first edge clears all.
   int su;
   int ph;
   // A stopped oscillator loses its start-up state, so a late restart
   // makes the controller wait again rather than switch at once.
   always @(posedge clk) begin
      if (!run) begin
         su <= 0;
         ph <= 0;
         ready <= 1'b0;
         tick <= 1'b0;
      end else begin
         su <= (su < START) ? su + 1 : su;
         ready <= (su >= START);
         ph <= (ph == PER - 1) ? 0 : ph + 1;
         tick <= ready && (ph == PER - 1);
      end
   end
endmodule

// ==== fcm_pkg.sv ====
// Constants, field layouts and types for the clock source mode controller.
package fcm_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 4;
   // Nominal untrimmed period of the internal reference oscillator.
   localparam int unsigned IREF_BASE_NS  = 30720;
   localparam int unsigned IREF_BASE_CYC = IREF_BASE_NS / CLK_PERIOD_NS;
   localparam int unsigned IREF_W        = 14;
   localparam int unsigned MEAS_W        = 24;
   localparam int unsigned FLL_SHIFT     = 9;     // Loop gain of 512.
   localparam logic [1:0]  SWITCH_TICKS  = 2'h3;
   localparam logic [1:0]  RELOCK_TICKS  = 2'h3;
   localparam logic [2:0]  FFE_REFERENCE_DIVIDER_BASE = 3'h2;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [2:0] ADDR_CTRL1 = 3'h0;
   localparam logic [2:0] ADDR_CTRL2 = 3'h1;
   localparam logic [2:0] ADDR_TRIM  = 3'h2;
   localparam logic [2:0] ADDR_STAT  = 3'h3;

   localparam int unsigned C1_CS_LSB    = 6;
   localparam int unsigned C1_REFERENCE_DIVIDER_LSB  = 3;
   localparam int unsigned C1_INTERNAL_REF_SELECT     = 2;
   localparam int unsigned C1_INTERNAL_REF_OUT_ENABLE   = 1;
   localparam int unsigned C1_IRSTEN    = 0;
   localparam int unsigned C2_BUS_DIVIDER_LSB  = 6;
   localparam int unsigned C2_LP        = 3;
   localparam int unsigned C2_EXTERNAL_REF_OUT_ENABLE   = 1;
   localparam int unsigned C2_ERSTEN    = 0;
   localparam int unsigned ST_LOCK      = 4;
   localparam int unsigned ST_MODE_LSB  = 2;
   localparam int unsigned ST_EXTRDY    = 1;
   localparam int unsigned ST_FINE_PERIOD_BIT     = 0;

   localparam logic [1:0] CS_RST    = 2'h0;
   localparam logic [2:0] REFERENCE_DIVIDER_RST  = 3'h0;
   localparam logic       INTERNAL_REF_SELECT_RST = 1'b1;
   localparam logic [1:0] BUS_DIVIDER_RST  = 2'h1;
   localparam logic [7:0] TRIM_POR  = 8'h80;
   localparam logic       FINE_PERIOD_BIT_POR = 1'b0;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      FCM_SRC_LOOP = 2'h0,
      FCM_SRC_INT  = 2'h1,
      FCM_SRC_EXT  = 2'h2,
      FCM_SRC_RSVD = 2'h3
   } fcm_src_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fcm_bus_req_t;

   typedef struct packed {
      logic main_clk;
      logic link_clk;
      logic iref_clk;
      logic eref_clk;
      logic ff_clk;
      logic ffe;
   } fcm_clk_out_t;

   typedef struct packed {
      fcm_src_t          cs;
      logic [2:0]        reference_divider;
      logic              internal_ref_select;
      logic              internal_ref_out_enable;
      logic              internal_ref_stop_enable;
      logic [1:0]        bus_divider;
      logic              lp;
      logic              external_ref_out_enable;
      logic              external_ref_stop_enable;
      logic [7:0]        trim;
      logic              fine_period_bit;
      logic [7:0]        rdata;
      logic [IREF_W-1:0] iref_cnt;
      logic              iref_tick;
      logic [6:0]        reference_divider_cnt;
      logic              ff_tick;
      logic              internal_ref_select_seen;
      logic [1:0]        lock_cnt;
      logic              locked;
      logic [MEAS_W-1:0] meas_cnt;
      logic [MEAS_W-1:0] ref_period;
      logic [MEAS_W-1:0] fll_cnt;
      logic              fll_tick;
      fcm_src_t          cur_src;
      fcm_src_t          pend_src;
      logic [1:0]        sw_cnt;
      logic [2:0]        bus_cnt;
      fcm_clk_out_t      outs;
   } fcm_state_t;

endpackage
